// ### design/rafc_top.sv
// alarm control and frequency output with axi4-lite registers
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Contract
// - alarm repeat bit picks one alarm per enable (0) or an alarm on every match (1).
// - alarm matches raise nothing unless the alarm enable bit is set.
// - the low bias bit drives the oscillator bias select output through a register, one cycle later.
// - in battery backup the frequency output works only with the backup output enable bit set.
// - frequency code 0 is off, 1..4 give 32768/4096/1024/64 Hz, 5..13 halve from 32 to 1/8 Hz.
module rafc_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // timebase and alarm sources
  input  wire logic        osc_tick,
  input  wire logic        alarm_match,
  input  wire logic        on_battery,
  // pins
  output logic             freq_out_irq_pin,
  output logic             osc_low_bias_select,
  output logic             irq,
  // axi4-lite write
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);
  rafc_pkg::rafc_state_s q_ff, nxt_q;

  // code to divider bit; the output toggles on that bit's rising, so bit k gives 32768/2^(k+2)
  function automatic logic [4:0] tap_of(input logic [3:0] fs);
    unique case (fs)
      4'h1:    tap_of = rafc_pkg::TAP_COPY;
      4'h2:    tap_of = rafc_pkg::TAP_4K;
      4'h3:    tap_of = rafc_pkg::TAP_1K;
      default: tap_of = {1'b0, fs} + rafc_pkg::TAP_OFS;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == rafc_pkg::OFS_CTRL) || (a == rafc_pkg::OFS_STAT) ||
             (a == rafc_pkg::OFS_MASK);
  endfunction

  // a write to the given offset commits in this cycle
  function automatic logic wr_now(input logic [7:0] ofs);
    wr_now = q_ff.have_aw && q_ff.have_w && !q_ff.bvalid && q_ff.wstrb[0] &&
             (q_ff.waddr == ofs);
  endfunction

  logic [4:0] tap;
  logic       fe_q;
  logic [rafc_pkg::DIV_W-1:0] div_n;
  logic       run_out;
  logic       fire;
  logic       tog;
  logic [1:0] ev;
  logic [7:0] wb;

  // the slowest code needs divider bit TAP_MAX
  if (rafc_pkg::DIV_W <= rafc_pkg::TAP_MAX) begin : g_div_chk
    $error("divider narrower than the slowest frequency code");
  end

  always_comb begin
    nxt_q = q_ff;
    tap = tap_of(q_ff.ctrl.fsel);
    div_n = q_ff.div + {{(rafc_pkg::DIV_W-1){1'b0}}, osc_tick};
    nxt_q.div = div_n;
    // low-frequency taps need the divider; 32768 Hz follows the tick itself
    run_out = (q_ff.ctrl.fsel != rafc_pkg::FS_OFF) && (q_ff.ctrl.fsel <= rafc_pkg::FS_LAST)
              && (!on_battery || q_ff.ctrl.bk_oe);
    fe_q = 1'b0;
    tog = 1'b0;
    if (tap != rafc_pkg::TAP_COPY) begin
      tog = osc_tick && div_n[tap] && !q_ff.div[tap];
    end
    if (!run_out) begin
      nxt_q.fout = 1'b0;
    end else if (tap == rafc_pkg::TAP_COPY) begin
      nxt_q.fout = osc_tick;
    end else if (tog) begin
      nxt_q.fout = !q_ff.fout;
      fe_q = !q_ff.fout;
    end
    // single mode raises once until rearmed by a control write that clears the enable
    fire = alarm_match && q_ff.ctrl.alm_en &&
           (q_ff.ctrl.repeat_sel || !q_ff.alm_done);
    if (fire && !q_ff.ctrl.repeat_sel) begin
      nxt_q.alm_done = 1'b1;
    end
    ev = {fe_q, fire};
    nxt_q.bias = q_ff.ctrl.low_bias;
    // write channel
    nxt_q.bvalid = q_ff.bvalid && !s_bready;
    if (s_awvalid && q_ff.awready) begin
      nxt_q.have_aw = 1'b1;
      nxt_q.waddr = s_awaddr;
      nxt_q.awready = 1'b0;
    end
    if (s_wvalid && q_ff.wready) begin
      nxt_q.have_w = 1'b1;
      nxt_q.wdata = s_wdata;
      nxt_q.wstrb = s_wstrb;
      nxt_q.wready = 1'b0;
    end
    wb = q_ff.wdata[7:0];
    if (q_ff.have_aw && q_ff.have_w && !q_ff.bvalid) begin
      nxt_q.have_aw = 1'b0;
      nxt_q.have_w = 1'b0;
      nxt_q.awready = 1'b1;
      nxt_q.wready = 1'b1;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = mapped(q_ff.waddr) ? rafc_pkg::RESP_OK : rafc_pkg::RESP_ERR;
      if (q_ff.wstrb[0]) begin
        if (q_ff.waddr == rafc_pkg::OFS_CTRL) begin
          nxt_q.ctrl = rafc_pkg::rafc_ctrl_s'(wb);
          if (!wb[rafc_pkg::B_ALMEN]) begin
            nxt_q.alm_done = 1'b0;
          end
        end
        if (q_ff.waddr == rafc_pkg::OFS_STAT) begin
          nxt_q.stat = q_ff.stat & ~wb[1:0];
        end
        if (q_ff.waddr == rafc_pkg::OFS_MASK) begin
          nxt_q.mask = wb[1:0] & rafc_pkg::ST_MASK_W;
        end
      end
    end
    // set wins over a same-cycle clear
    nxt_q.stat = nxt_q.stat | ev;
    nxt_q.irq = |(nxt_q.stat & nxt_q.mask);
    // read channel
    if (q_ff.rvalid && s_rready) begin
      nxt_q.rvalid = 1'b0;
      nxt_q.arready = 1'b1;
    end
    if (s_arvalid && q_ff.arready) begin
      nxt_q.arready = 1'b0;
      nxt_q.rvalid = 1'b1;
      nxt_q.rresp = mapped(s_araddr) ? rafc_pkg::RESP_OK : rafc_pkg::RESP_ERR;
      unique case (s_araddr)
        rafc_pkg::OFS_CTRL: nxt_q.rdata = {24'h00_0000, q_ff.ctrl};
        rafc_pkg::OFS_STAT: nxt_q.rdata = {30'h0000_0000, q_ff.stat};
        rafc_pkg::OFS_MASK: nxt_q.rdata = {30'h0000_0000, q_ff.mask};
        default:            nxt_q.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= '0;
      q_ff.ctrl <= rafc_pkg::rafc_ctrl_s'(rafc_pkg::CTRL_RST);
      q_ff.awready <= 1'b1;
      q_ff.wready <= 1'b1;
      q_ff.arready <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign freq_out_irq_pin = q_ff.fout;
  assign osc_low_bias_select = q_ff.bias;
  assign irq = q_ff.irq;
  assign s_awready = q_ff.awready;
  assign s_wready = q_ff.wready;
  assign s_bvalid = q_ff.bvalid;
  assign s_bresp = q_ff.bresp;
  assign s_arready = q_ff.arready;
  assign s_rvalid = q_ff.rvalid;
  assign s_rdata = q_ff.rdata;
  assign s_rresp = q_ff.rresp;

  a_alarm_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q_ff.stat[0]) |-> $past(q_ff.ctrl.alm_en))
    else $error("alarm raised while disabled");
  a_single_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (q_ff.alm_done && !q_ff.ctrl.repeat_sel && alarm_match && !s_awvalid) |=> !fire)
    else $error("single alarm repeated");
  a_repeat_fire: assert property (@(posedge aclk) disable iff (!aresetn)
    (alarm_match && q_ff.ctrl.alm_en && q_ff.ctrl.repeat_sel) |=> q_ff.stat[0])
    else $error("periodic alarm missed");
  a_bias_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 osc_low_bias_select == $past(q_ff.ctrl.low_bias))
    else $error("bias select wrong");
  a_backup_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (on_battery && !q_ff.ctrl.bk_oe) |=> !freq_out_irq_pin)
    else $error("output active in backup");
  a_code_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (q_ff.ctrl.fsel == rafc_pkg::FS_OFF) |=> !freq_out_irq_pin)
    else $error("output active when off");
  a_div_step: assert property (@(posedge aclk) disable iff (!aresetn)
    osc_tick |=> q_ff.div == $past(q_ff.div) + 1'b1)
    else $error("divider did not count");
  a_tap_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    (q_ff.ctrl.fsel == 4'h1 && run_out && osc_tick) |=> freq_out_irq_pin)
    else $error("32768 Hz path wrong");
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_bvalid && !s_bready) |=> s_bvalid)
    else $error("write response dropped early");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_bvalid && !s_bready) |=> $stable(s_bresp))
    else $error("write response code changed");
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_rvalid && !s_rready) |=> s_rvalid)
    else $error("read response dropped early");
  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_rvalid && !s_rready) |=> $stable(s_rdata))
    else $error("read data changed while waiting");
  a_rresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_rvalid && !s_rready) |=> $stable(s_rresp))
    else $error("read response code changed");
  a_bvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_bvalid && s_bready) |=> !s_bvalid)
    else $error("write response repeated");
  a_rvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_rvalid && s_rready) |=> !s_rvalid)
    else $error("read response repeated");
  a_ar_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_arvalid && s_arready) |=> (s_rvalid && !s_arready))
    else $error("read not answered next cycle");
  a_aw_taken: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_awvalid && s_awready) |=> !s_awready)
    else $error("write address not closed");
  a_w_taken: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_wvalid && s_wready) |=> !s_wready)
    else $error("write data not closed");
  a_resp_after: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_bvalid) |-> $past(!s_awready && !s_wready))
    else $error("response before address and data");
  a_rd_ctrl: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_arvalid && s_arready && s_araddr == rafc_pkg::OFS_CTRL) |=>
    s_rdata == {24'h00_0000, $past(q_ff.ctrl)})
    else $error("control readback wrong");
  a_rd_stat: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_arvalid && s_arready && s_araddr == rafc_pkg::OFS_STAT) |=>
    s_rdata == {30'h0000_0000, $past(q_ff.stat)})
    else $error("status readback wrong");
  a_rd_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_arvalid && s_arready && s_araddr == rafc_pkg::OFS_MASK) |=>
    s_rdata == {30'h0000_0000, $past(q_ff.mask)})
    else $error("mask readback wrong");
  a_rd_err: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_arvalid && s_arready && !mapped(s_araddr)) |=>
    (s_rresp == rafc_pkg::RESP_ERR && s_rdata == 32'h0000_0000))
    else $error("unmapped read not refused");
  a_wr_err: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(s_bvalid) && !mapped(q_ff.waddr)) |-> s_bresp == rafc_pkg::RESP_ERR)
    else $error("unmapped write not refused");
  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rvalid |-> s_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_aw_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    q_ff.have_aw |-> !s_awready)
    else $error("address accepted while busy");
  a_w_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    q_ff.have_w |-> !s_wready)
    else $error("data accepted while busy");
  a_alarm_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (alarm_match && q_ff.ctrl.alm_en && !q_ff.alm_done) |=> q_ff.stat[rafc_pkg::ST_ALARM])
    else $error("enabled alarm not raised");
  a_single_done: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q_ff.alm_done) |-> $past(fire && !q_ff.ctrl.repeat_sel))
    else $error("single alarm latched without event");
  a_done_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(q_ff.alm_done) |->
    $past(wr_now(rafc_pkg::OFS_CTRL) && !q_ff.wdata[rafc_pkg::B_ALMEN]))
    else $error("single alarm rearmed without disable");
  a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
    !$stable(q_ff.ctrl) |-> $past(wr_now(rafc_pkg::OFS_CTRL)))
    else $error("control changed without a write");
  a_fedge_set: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(freq_out_irq_pin) && $past(q_ff.ctrl.fsel) != 4'h1) |->
    q_ff.stat[rafc_pkg::ST_FEDGE])
    else $error("output edge not recorded");
  a_out_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !run_out |=> !freq_out_irq_pin)
    else $error("output active while gated");
  a_fast_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_out && tap == rafc_pkg::TAP_COPY) |=> freq_out_irq_pin == $past(osc_tick))
    else $error("fast output does not follow tick");
  a_fout_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_out && tap != rafc_pkg::TAP_COPY && !tog) |=> $stable(freq_out_irq_pin))
    else $error("divided output moved off its tap");
  a_div_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !osc_tick |=> $stable(q_ff.div))
    else $error("divider moved without tick");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(q_ff.stat & q_ff.mask))
    else $error("interrupt level wrong");
  // sticky bits only fall on a write of one
  for (genvar i = 0; i < 2; i++) begin : g_stat
    a_stat_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      (q_ff.stat[i] && !(wr_now(rafc_pkg::OFS_STAT) && q_ff.wdata[i])) |=> q_ff.stat[i])
      else $error("status bit lost");
    a_irq_bit: assert property (@(posedge aclk) disable iff (!aresetn)
      (q_ff.stat[i] && q_ff.mask[i]) |-> irq)
      else $error("unmasked status without interrupt");
  end
endmodule

// ### design/rafc_pkg.sv
// package for the rtc alarm and frequency output control block
package rafc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_EXT  = 8'h0C;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int unsigned B_REPEAT = 7;
  localparam int unsigned B_ALMEN  = 6;
  localparam int unsigned B_LOWB   = 5;
  localparam int unsigned B_BKOE   = 4;
  localparam int unsigned FS_W     = 4;
  localparam logic [3:0] FS_OFF  = 4'h0;
  localparam logic [3:0] FS_LAST = 4'hD;
  localparam int unsigned DIV_W = 18;
  localparam logic [4:0] TAP_COPY = 5'h1F;
  localparam logic [4:0] TAP_4K   = 5'h01;
  localparam logic [4:0] TAP_1K   = 5'h03;
  localparam logic [4:0] TAP_OFS  = 5'h03;
  localparam int unsigned TAP_MAX = 16;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  localparam int unsigned ST_ALARM = 0;
  localparam int unsigned ST_FEDGE = 1;
  localparam logic [1:0] ST_MASK_W = 2'b11;

  typedef struct packed {
    logic       repeat_sel;
    logic       alm_en;
    logic       low_bias;
    logic       bk_oe;
    logic [3:0] fsel;
  } rafc_ctrl_s;

  typedef struct packed {
    rafc_ctrl_s        ctrl;
    logic [1:0]        stat;
    logic [1:0]        mask;
    logic [DIV_W-1:0]  div;
    logic              alm_done;
    logic              fout;
    logic              irq;
    logic              bias;
    logic              awready;
    logic              wready;
    logic              have_aw;
    logic              have_w;
    logic [7:0]        waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } rafc_state_s;
endpackage

// ### dv/rafc_top_test.sv
// self-checking bench for the alarm and frequency output control block
`timescale 1ns/1ps
module rafc_top_test;
  logic        aclk = 0, aresetn = 0, osc_tick = 0, alarm_match = 0, on_battery = 0;
  logic [7:0]  s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, s_rdata;
  logic [3:0]  s_wstrb = 4'hF;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic        freq_out_irq_pin, osc_low_bias_select, irq;
  logic [1:0]  s_bresp, s_rresp, r;
  logic [31:0] d;
  int          err_count = 0, total_checks = 0, n, e;
  logic [7:0]  v;
  logic        p;
  rafc_top dut (.aclk, .aresetn, .osc_tick, .alarm_match, .on_battery, .freq_out_irq_pin,
    .osc_low_bias_select, .irq, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  always #10 aclk = ~aclk;
  // tick on every other edge so a copied tick still shows edges
  always @(posedge aclk) osc_tick <= ~osc_tick;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    s_awaddr <= a;
    s_wdata <= {24'h00_0000, x};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic hit;
    alarm_match <= 1'b1;
    @(posedge aclk);
    alarm_match <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  // model: rising edges in 2048 ticks, period in ticks by binary division
  function automatic int rises(int c, bit off);
    if (off || c == 0 || c > 13) return 0;
    if (c == 1) return 2048;
    return 2048 / (c == 2 ? 8 : c == 3 ? 32 : 512 << (c - 4));
  endfunction
  initial begin
    #1_500_000;
    err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(53));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(rafc_pkg::OFS_CTRL); chk(d, 32'h0000_0000);
    rd(8'h40); chk(r, rafc_pkg::RESP_ERR);
    chk(d, 32'h0000_0000);
    wr(rafc_pkg::OFS_MASK, 8'h01);
    hit(); rd(rafc_pkg::OFS_STAT); chk(d, 32'h0000_0000);
    wr(rafc_pkg::OFS_CTRL, 8'h40);
    hit(); rd(rafc_pkg::OFS_STAT); chk(d, 32'h0000_0001);
    chk(irq, 1'b1);
    wr(rafc_pkg::OFS_STAT, 8'h01); chk(irq, 1'b0);
    hit(); rd(rafc_pkg::OFS_STAT); chk(d, 32'h0000_0000);
    wr(rafc_pkg::OFS_CTRL, 8'hC0);
    for (int i = 0; i < 2; i++) begin
      wr(rafc_pkg::OFS_STAT, 8'h01);
      hit(); rd(rafc_pkg::OFS_STAT); chk(d, 32'h0000_0001);
    end
    wr(rafc_pkg::OFS_MASK, 8'h00); chk(irq, 1'b0);
    for (int c = 0; c < 7; c++) begin
      v = {2'b00, 2'($urandom), (c == 6) ? 4'hE : 4'(c)};
      on_battery <= 1'($urandom);
      wr(rafc_pkg::OFS_CTRL, v);
      rd(rafc_pkg::OFS_CTRL); chk(d, {24'h00_0000, v});
      chk(osc_low_bias_select, v[5]);
      n = 0;
      e = rises(v[3:0], on_battery && !v[4]);
      @(negedge aclk);
      p = freq_out_irq_pin;
      repeat (4096) begin
        @(negedge aclk);
        n += (freq_out_irq_pin && !p) ? 1 : 0;
        p = freq_out_irq_pin;
      end
      chk(n, e);
      @(posedge aclk);
    end
    print_verdict();
  end
endmodule
